/* rtl/pds_defines.svh */
// register offsets, field positions, reset values and timing counts
`ifndef PDS_DEFINES_SVH
`define PDS_DEFINES_SVH
`define PDS_OFS_DEADBAND 8'h00
`define PDS_OFS_SHUTDOWN 8'h04
`define PDS_OFS_UNITCTRL 8'h08
`define PDS_OFS_PIN_EN 8'h0C
`define PDS_OFS_STATUS 8'h10
`define PDS_BIT_RESTART 7
`define PDS_BIT_ASE 7
`define PDS_POS_SRC 4
`define PDS_POS_PSS_AC 2
`define PDS_POS_PSS_BD 0
`define PDS_POS_POL 0
`define PDS_POS_MODE 2
`define PDS_BIT_PERIOD_FLAG 0
`define PDS_BIT_SHUT_HOLD 1
`define PDS_BIT_CAUSE 2
`define PDS_RST_DEADBAND 8'h00
`define PDS_RST_SHUTDOWN 8'h00
`define PDS_RST_UNITCTRL 4'h0
`define PDS_RST_PIN_EN 4'h0
`define PDS_CLK_NS 10
`define PDS_TCY_NS 10
`define PDS_TCY_CYCLES (`PDS_TCY_NS / `PDS_CLK_NS)
`endif

/* rtl/pds_pkg.sv */
// types shared by the dead-band and auto-shutdown block
package pds_pkg;
    // output configurations of the unit
    typedef enum logic [1:0] {
        PDS_MODE_SINGLE,
        PDS_MODE_HALF,
        PDS_MODE_FULL_FWD,
        PDS_MODE_FULL_REV
    } pds_mode_e;
    // dead-band and restart register layout
    typedef struct packed {
        logic restart_enable;
        logic [6:0] deadband_count;
    } pds_db_s;
    // shutdown control register layout
    typedef struct packed {
        logic shutdown_status_flag;
        logic [2:0] shutdown_source_select;
        logic [1:0] pair_ac_shutdown_state;
        logic [1:0] pair_bd_shutdown_state;
    } pds_sc_s;
    // unit control register layout
    typedef struct packed {
        pds_mode_e mode;
        logic [1:0] output_polarity_select;
    } pds_uc_s;
    // one set of four output pins
    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic d;
    } pds_pins_s;
endpackage

/* rtl/pds_top.sv */
// dead-band delay, auto-shutdown and output stage of an enhanced pwm unit
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "pds_defines.svh"

////////////////////////////////////////////////////////////////////////////
// one dead-band delay channel: delays inactive-to-active, not the reverse
module pds_deadband (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic sched,
    input wire logic [6:0] count,
    output logic act
);
    import pds_pkg::*;
    logic sched_prev_q;
    logic done_q;
    logic [6:0] cnt_q;
    logic rise;

    assign rise = sched & ~sched_prev_q;

    // previous scheduled level, for edge detection
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sched_prev_q <= 1'b0;
        end else begin
            sched_prev_q <= sched;
        end
    end

    // counter restarts at every scheduled activation
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !sched) begin
            cnt_q <= 7'h00;
            done_q <= 1'b0;
        end else if (rise) begin
            cnt_q <= (count == 7'h00) ? 7'h00 : count - 7'h01;
            done_q <= (count <= 7'h01);
        end else if (!done_q) begin
            cnt_q <= cnt_q - 7'h01;
            done_q <= (cnt_q <= 7'h01);
        end
    end

    // a short pulse ends before done and stays inactive
    // falling edge passes at once
    assign act = sched & (rise ? (count == 7'h00) : done_q);
endmodule // pds_deadband

////////////////////////////////////////////////////////////////////////////
module pds_top (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic period_start,
    input wire logic pwm_raw,
    input wire logic fault_input_n,
    input wire logic comparator1,
    input wire logic comparator2,
    output logic pwm_out_a,
    output logic pwm_out_a_oe,
    output logic pwm_out_b,
    output logic pwm_out_b_oe,
    output logic pwm_out_c,
    output logic pwm_out_c_oe,
    output logic pwm_out_d,
    output logic pwm_out_d_oe
);
    import pds_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations
    pds_db_s db_q;
    pds_sc_s sc_q;
    pds_uc_s uc_q;
    logic [3:0] pin_en_q;
    logic period_flag_q, ase_q, hold_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic [2:0] s1_q, s2_q, s3_q, filt_q;
    logic addr_take;
    logic wr_db, wr_sc, wr_uc, wr_pin, wr_st;
    logic wr_ase_set, wr_ase_clr;
    logic enhanced, cause_s, cause_raw, shut_now;
    logic act_a, act_b;
    logic [6:0] db_eff;
    logic [31:0] rd_mux;
    pds_pins_s act, lvl, oe;

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave, zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign addr_take = hsel & htrans[1] & hready;

    // write address phase captured for the following data phase
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= addr_take & hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    // write strobes in the data phase
    assign wr_db = wr_pend_q & (wr_addr_q == `PDS_OFS_DEADBAND);
    assign wr_sc = wr_pend_q & (wr_addr_q == `PDS_OFS_SHUTDOWN);
    assign wr_uc = wr_pend_q & (wr_addr_q == `PDS_OFS_UNITCTRL);
    assign wr_pin = wr_pend_q & (wr_addr_q == `PDS_OFS_PIN_EN);
    assign wr_st = wr_pend_q & (wr_addr_q == `PDS_OFS_STATUS);
    assign wr_ase_set = wr_sc & hwdata[`PDS_BIT_ASE];
    assign wr_ase_clr = wr_sc & ~hwdata[`PDS_BIT_ASE];

    // read mux, unmapped offsets read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            `PDS_OFS_DEADBAND: rd_mux[7:0] = db_q;
            `PDS_OFS_SHUTDOWN: rd_mux[7:0] = {ase_q, sc_q[6:0]};
            `PDS_OFS_UNITCTRL: rd_mux[3:0] = uc_q;
            `PDS_OFS_PIN_EN: rd_mux[3:0] = pin_en_q;
            `PDS_OFS_STATUS: begin
                rd_mux[`PDS_BIT_PERIOD_FLAG] = period_flag_q;
                rd_mux[`PDS_BIT_SHUT_HOLD] = shut_now;
                rd_mux[`PDS_BIT_CAUSE] = cause_s;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data registered for the data phase
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_take & ~hwrite) begin
            hrdata_q <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers; the shutdown flag itself lives in ase_q
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            db_q <= `PDS_RST_DEADBAND;
            sc_q <= `PDS_RST_SHUTDOWN;
            uc_q <= `PDS_RST_UNITCTRL;
            pin_en_q <= `PDS_RST_PIN_EN;
        end else begin
            if (wr_db) begin
                db_q <= hwdata[7:0];
            end
            if (wr_sc) begin
                sc_q <= {1'b0, hwdata[6:0]};
            end
            if (wr_uc) begin
                uc_q <= hwdata[3:0];
            end
            if (wr_pin) begin
                pin_en_q <= hwdata[3:0];
            end
        end
    end

    // period flag, set wins over write-one-to-clear
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            period_flag_q <= 1'b0;
        end else if (period_start) begin
            period_flag_q <= 1'b1;
        end else if (wr_st & hwdata[`PDS_BIT_PERIOD_FLAG]) begin
            period_flag_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault sources: three-stage synchronisers with agreement filter
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s1_q <= 3'h4;
            s2_q <= 3'h4;
            s3_q <= 3'h4;
        end else begin
            s1_q <= {fault_input_n, comparator2, comparator1};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts once the second and third stages agree
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            filt_q <= 3'h4;
        end else begin
            filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
        end
    end

    // enhanced modes are half and full bridge
    assign enhanced = (uc_q.mode != PDS_MODE_SINGLE);

    // source select decode, fault pin active low
    assign cause_s = enhanced & (
        (sc_q.shutdown_source_select[0] & filt_q[0]) |
        (sc_q.shutdown_source_select[1] & filt_q[1]) |
        (sc_q.shutdown_source_select[2] & ~filt_q[2]));

    // unclocked copy forces the pins before any edge
    assign cause_raw = enhanced & (
        (sc_q.shutdown_source_select[0] & comparator1) |
        (sc_q.shutdown_source_select[1] & comparator2) |
        (sc_q.shutdown_source_select[2] & ~fault_input_n));

    ////////////////////////////////////////////////////////////////////////
    // shutdown status flag: set wins, clears blocked while cause persists
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ase_q <= 1'b0;
        end else if (cause_s | (wr_ase_set & enhanced)) begin
            ase_q <= 1'b1;
        end else if (db_q.restart_enable) begin
            ase_q <= 1'b0;
        end else if (wr_ase_clr) begin
            ase_q <= 1'b0;
        end
    end

    // outputs held in shutdown until a period starts with flag clear
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            hold_q <= 1'b0;
        end else if (ase_q) begin
            hold_q <= 1'b1;
        end else if (period_start) begin
            hold_q <= 1'b0;
        end
    end

    assign shut_now = enhanced & (hold_q | ase_q | cause_raw);

    ////////////////////////////////////////////////////////////////////////
    // dead band only in half-bridge mode
    assign db_eff = (uc_q.mode == PDS_MODE_HALF) ? db_q.deadband_count
                                                 : 7'h00;

    // one counter per complementary output
    pds_deadband u_db_a (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .sched(pwm_raw),
        .count(db_eff),
        .act(act_a)
    );

    pds_deadband u_db_b (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .sched(~pwm_raw),
        .count(db_eff),
        .act(act_b)
    );

    // active levels per mode, before polarity
    always_comb begin
        act = '0;
        case (uc_q.mode)
            PDS_MODE_SINGLE: act.a = pwm_raw;
            PDS_MODE_HALF: begin
                act.a = act_a;
                act.b = act_b;
            end
            PDS_MODE_FULL_FWD: begin
                act.a = 1'b1;
                act.d = pwm_raw;
            end
            PDS_MODE_FULL_REV: begin
                act.c = 1'b1;
                act.b = pwm_raw;
            end
            default: act = '0;
        endcase
    end

    // polarity per pair, then shutdown states override
    always_comb begin
        lvl.a = act.a ^ uc_q.output_polarity_select[1];
        lvl.c = act.c ^ uc_q.output_polarity_select[1];
        lvl.b = act.b ^ uc_q.output_polarity_select[0];
        lvl.d = act.d ^ uc_q.output_polarity_select[0];
        oe = pin_en_q;
        if (shut_now) begin
            lvl.a = sc_q.pair_ac_shutdown_state[0];
            lvl.c = sc_q.pair_ac_shutdown_state[0];
            lvl.b = sc_q.pair_bd_shutdown_state[0];
            lvl.d = sc_q.pair_bd_shutdown_state[0];
            oe.a = pin_en_q[3] & ~sc_q.pair_ac_shutdown_state[1];
            oe.c = pin_en_q[1] & ~sc_q.pair_ac_shutdown_state[1];
            oe.b = pin_en_q[2] & ~sc_q.pair_bd_shutdown_state[1];
            oe.d = pin_en_q[0] & ~sc_q.pair_bd_shutdown_state[1];
        end
    end

    assign pwm_out_a = lvl.a;
    assign pwm_out_b = lvl.b;
    assign pwm_out_c = lvl.c;
    assign pwm_out_d = lvl.d;
    assign pwm_out_a_oe = oe.a;
    assign pwm_out_b_oe = oe.b;
    assign pwm_out_c_oe = oe.c;
    assign pwm_out_d_oe = oe.d;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_ase_on_cause: assert property (cause_s |=> ase_q)
        else $error("flag not set by shutdown cause");
    a_restart_clear: assert property (
        db_q.restart_enable & ase_q & ~cause_s & ~wr_ase_set |=> ~ase_q)
        else $error("auto restart did not clear flag");
    a_no_auto_clear: assert property (
        ~db_q.restart_enable & ase_q & ~wr_ase_clr |=> ase_q)
        else $error("flag cleared without software");
    a_clear_blocked: assert property (
        wr_ase_clr & cause_s |=> ase_q)
        else $error("flag write taken while cause active");
    a_force_write: assert property (wr_ase_set & enhanced |=> ase_q)
        else $error("write of one did not force shutdown");
    a_hold_period: assert property (
        period_start & ase_q |=> hold_q & shut_now)
        else $error("shutdown released during held period");
    a_resume_start: assert property (
        hold_q & ~ase_q & ~period_start & enhanced |=> shut_now)
        else $error("output resumed mid period");
    a_async_force: assert property (cause_raw |-> shut_now)
        else $error("raw cause did not force shutdown");
    a_deadband_gap: assert property (
        uc_q.mode == PDS_MODE_HALF & $rose(pwm_raw) & db_eff == 7'h03
        & $stable(db_eff) |-> ~act_a ##1 ~act_a ##1 ~act_a)
        else $error("activation came before dead band");
    a_fall_fast: assert property (
        uc_q.mode == PDS_MODE_HALF & ~pwm_raw & ~shut_now
        |-> pwm_out_a == uc_q.output_polarity_select[1])
        else $error("inactive edge was delayed");
    a_complement: assert property (
        uc_q.mode == PDS_MODE_HALF & pwm_raw & ~shut_now
        |-> pwm_out_b == uc_q.output_polarity_select[0])
        else $error("b output active with a scheduled");
    a_single_off: assert property (~enhanced |-> ~shut_now)
        else $error("shutdown outside enhanced mode");
    a_polarity_a: assert property (
        uc_q.mode == PDS_MODE_FULL_FWD & ~shut_now
        |-> pwm_out_a == ~uc_q.output_polarity_select[1])
        else $error("a polarity wrong");

    c_shut_restart: cover property (ase_q ##1 ~ase_q ##[1:50] ~shut_now);
    c_deadband: cover property ($rose(pwm_raw) & db_eff > 7'h01);
    c_force: cover property (wr_ase_set & enhanced & ~cause_s);
    c_blocked: cover property (wr_ase_clr & cause_s);
endmodule // pds_top

/* sim/pds_bridge_model.sv */
// model of the bridge switches, drivers and fault sources beyond the pins
`timescale 1ns/10ps
module pds_bridge_model (
    input wire logic [2:0] cause,
    input wire pds_pkg::pds_pins_s pin_out,
    input wire pds_pkg::pds_pins_s pin_oe,
    output logic fault_input_n,
    output logic comparator1,
    output logic comparator2,
    output pds_pkg::pds_pins_s pin_lvl,
    output logic shoot
);
    import pds_pkg::*;
    // fault line trips low, comparators trip high; bits are fault, c2, c1
    assign fault_input_n = ~cause[2];
    assign comparator2 = cause[1];
    assign comparator1 = cause[0];
    // external pull-downs keep a released pin, and its switch, off
    assign pin_lvl = pin_oe & pin_out;
    // sticky flag: both switches of the a/b leg conduct at once
    initial shoot = 1'b0;
    always @(posedge pin_lvl.a or posedge pin_lvl.b) begin
        #1; // let zero-delay edges of the other leg settle first
        if (pin_lvl.a && pin_lvl.b) begin
            shoot = 1'b1;
        end
    end
endmodule // pds_bridge_model

/* sim/pwm_deadband_autoshutdown_test.sv */
// self-checking bench for the dead-band and auto-shutdown block
`timescale 1ns/10ps
module pwm_deadband_autoshutdown_test;
    import pds_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [31:0] hrdata;
    logic period_start = 1'b0;
    logic pwm_raw = 1'b0;
    logic [2:0] cause = 3'h0;
    logic fault_input_n, comparator1, comparator2, shoot;
    pds_pins_s pins, oes, lvl;
    logic [31:0] rv, rx, seed = 32'h0000A764;
    int err_total = 0;
    int tests_run = 0;

    ////////////////////////////////////////////////////////////////////////
    // clock, design and far side
    always #5 clk_sys = ~clk_sys;
    pds_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .period_start(period_start),
        .pwm_raw(pwm_raw), .fault_input_n(fault_input_n),
        .comparator1(comparator1), .comparator2(comparator2),
        .pwm_out_a(pins.a), .pwm_out_a_oe(oes.a), .pwm_out_b(pins.b),
        .pwm_out_b_oe(oes.b), .pwm_out_c(pins.c), .pwm_out_c_oe(oes.c),
        .pwm_out_d(pins.d), .pwm_out_d_oe(oes.d));
    pds_bridge_model bridge (.cause(cause), .pin_out(pins), .pin_oe(oes),
        .fault_input_n(fault_input_n), .comparator1(comparator1),
        .comparator2(comparator2), .pin_lvl(lvl), .shoot(shoot));

    ////////////////////////////////////////////////////////////////////////
    // helpers: random source, expectation, compare, bus cycle
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // shutdown expected when any live cause is among the selected ones
    function automatic logic shut_exp(input logic [2:0] sel, c);
        return |(sel & c);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one single transfer: address phase, then data phase
    task automatic bus(input logic [7:0] a, input logic w,
        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
    endtask
    // poll the status flag until it reaches v, at most 21 reads
    task automatic wait_flag(input logic v);
        bus(8'h04, 1'b0, 32'h0, rv);
        for (int i = 0; i < 20 && rv[7] !== v; i++) begin
            bus(8'h04, 1'b0, 32'h0, rv);
        end
    endtask
    // one period-start pulse
    task automatic tick();
        @(posedge clk_sys);
        period_start <= 1'b1;
        @(posedge clk_sys);
        period_start <= 1'b0;
        #1;
    endtask
    // raw edge to lvl; the output going active waits n cycles
    task automatic db_edge(input logic lvl_in, input int n);
        logic on, off;
        @(posedge clk_sys);
        pwm_raw <= lvl_in;
        for (int k = 0; k <= n + 1; k++) begin
            if (k > 0) @(posedge clk_sys);
            #1;
            on = lvl_in ? pins.a : pins.b;
            off = lvl_in ? pins.b : pins.a;
            check({31'h0, on}, {31'h0, k >= n});
            check({31'h0, off}, 32'h0);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        #400000;
        err_total++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        // reset values, an unmapped place, random read-back
        for (int i = 0; i < 5; i++) begin
            bus(i < 4 ? 8'(i * 4) : 8'h40, 1'b0, 32'h0, rv);
            check(rv, 32'h0);
        end
        check({31'h0, hresp}, 32'h0);
        repeat (4) begin
            rv = xs();
            bus(8'h00, 1'b1, rv, rv);
            bus(8'h00, 1'b0, 32'h0, rv);
            check(rv, {24'h0, seed[7:0]});
        end
        // half mode; one full period before the pins are driven
        bus(8'h08, 1'b1, 32'h4, rv);
        bus(8'h10, 1'b1, 32'h1, rv);
        bus(8'h10, 1'b0, 32'h0, rv);
        check({31'h0, rv[0]}, 32'h0);
        tick();
        tick();
        bus(8'h10, 1'b0, 32'h0, rv);
        check({31'h0, rv[0]}, 32'h1);
        bus(8'h0C, 1'b1, 32'hF, rv);
        // dead band at zero, three and a random count
        for (int i = 0; i < 3; i++) begin
            rv = xs();
            rv = (i == 0) ? 32'h0 : (i == 1) ? 32'h3 : {29'h0, rv[2:0]} + 1;
            bus(8'h00, 1'b1, rv, rx);
            db_edge(1'b1, int'(rv));
            db_edge(1'b0, int'(rv));
        end
        // dead band longer than the high time keeps a inactive
        bus(8'h00, 1'b1, 32'h6, rv);
        pwm_raw <= 1'b1;
        repeat (3) begin
            @(posedge clk_sys);
            #1;
            check({31'h0, pins.a}, 32'h0);
        end
        @(posedge clk_sys);
        pwm_raw <= 1'b0;
        check({31'h0, shoot}, 32'h0);
        // every source code against every single cause, auto restart
        bus(8'h00, 1'b1, 32'h80, rv);
        repeat (8) @(posedge clk_sys);
        for (int s = 0; s < 8; s++) begin
            for (int c = 0; c < 3; c++) begin
                bus(8'h04, 1'b1, {24'h0, 1'b0, 3'(s), 4'h4}, rv);
                cause <= 3'h1 << c;
                @(posedge clk_sys);
                #1;
                check({31'h0, pins.a}, shut_exp(3'(s), cause));
                check({31'h0, pins.b}, !shut_exp(3'(s), cause));
                wait_flag(shut_exp(3'(s), cause));
                check({31'h0, rv[7]}, shut_exp(3'(s), cause));
                cause <= 3'h0;
                wait_flag(1'b0);
                check({31'h0, rv[7]}, 32'h0);
                tick();
                check({31'h0, pins.a}, 32'h0);
            end
        end
        // comparator cause is a level; a/c released, b/d driven high
        bus(8'h04, 1'b1, 32'h39, rv);
        cause <= 3'h2;
        @(posedge clk_sys);
        #1;
        check({30'h0, oes.a, oes.c}, 32'h0);
        check({30'h0, lvl.a, pins.b}, 32'h1);
        wait_flag(1'b1);
        bus(8'h04, 1'b1, 32'h39, rv);
        bus(8'h04, 1'b0, 32'h0, rv);
        check({31'h0, rv[7]}, 32'h1);
        cause <= 3'h0;
        wait_flag(1'b0);
        check({31'h0, rv[7]}, 32'h0);
        tick();
        // restart disabled: flag stays until software clears it
        bus(8'h00, 1'b1, 32'h0, rv);
        bus(8'h04, 1'b1, 32'h44, rv);
        cause <= 3'h4;
        wait_flag(1'b1);
        bus(8'h04, 1'b1, 32'h44, rv);
        bus(8'h04, 1'b0, 32'h0, rv);
        check({31'h0, rv[7]}, 32'h1);
        cause <= 3'h0;
        repeat (10) @(posedge clk_sys);
        bus(8'h04, 1'b0, 32'h0, rv);
        check({31'h0, rv[7]}, 32'h1);
        bus(8'h04, 1'b1, 32'h44, rv);
        bus(8'h04, 1'b0, 32'h0, rv);
        check({31'h0, rv[7]}, 32'h0);
        #1;
        check({31'h0, pins.a}, 32'h1);
        tick();
        check({31'h0, pins.a}, 32'h0);
        // software forces a shutdown with no source selected
        bus(8'h04, 1'b1, 32'h84, rv);
        #1;
        check({31'h0, pins.a}, 32'h1);
        bus(8'h04, 1'b0, 32'h0, rv);
        check({31'h0, rv[7]}, 32'h1);
        tick();
        check({31'h0, pins.a}, 32'h1);
        bus(8'h04, 1'b1, 32'h04, rv);
        tick();
        // single mode: the fault pin has no effect
        bus(8'h08, 1'b1, 32'h0, rv);
        bus(8'h04, 1'b1, 32'h44, rv);
        cause <= 3'h4;
        repeat (8) @(posedge clk_sys);
        #1;
        check({31'h0, pins.a}, {31'h0, pwm_raw});
        bus(8'h04, 1'b0, 32'h0, rv);
        check({31'h0, rv[7]}, 32'h0);
        cause <= 3'h0;
        // polarity per pin pair, changed only with the pins released
        pwm_raw <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            bus(8'h0C, 1'b1, 32'h0, rv);
            bus(8'h08, 1'b1, 32'(4 + p), rv);
            bus(8'h0C, 1'b1, 32'hF, rv);
            repeat (2) @(posedge clk_sys);
            #1;
            check({30'h0, pins.a, pins.b}, {30'h0, ~p[1], p[0]});
        end
        // full-bridge steering, mode set with the pins released
        for (int m = 2; m < 4; m++) begin
            bus(8'h0C, 1'b1, 32'h0, rv);
            bus(8'h08, 1'b1, 32'(m * 4), rv);
            bus(8'h0C, 1'b1, 32'hF, rv);
            #1;
            check({28'h0, pins}, (m == 2) ? 32'h9 : 32'h6);
        end
        finish_test();
    end
endmodule // pwm_deadband_autoshutdown_test
